/* File: rtl/flip_core.sv */
// Four-level interrupt priority and vectoring controller.
//
// Overview of operation
// RULE1 - Level is {high bit, low bit}; 00 lowest, 11 highest.
// RULE2 - Only a strictly higher level preempts a running service routine.
// RULE3 - Among pending requests, the higher programmed level wins.
// RULE4 - Fixed rank breaks ties only among requests of equal level.
// RULE5 - Rank order runs ext0 first down to watchdog last.
// RULE6 - Vectors for ext0, timer0, ext1, timer1, serial0, timer2, adc.
// RULE7 - Vectors for two-wire, serial1, spi, ext2 to ext5.
// RULE8 - Vectors for pwm period, brake, timer3, capture, nvm, watchdog.
// RULE9 - Enable A bits 0 to 6 gate the first seven sources.
// RULE10 - Enable B gates two-wire, ext2 to ext5, watchdog and serial1.
// RULE11 - Enable C bits 0 to 5 gate spi through nvm.
// RULE12 - Only ext0 and ext1 requests wake the chip from power down.
// RULE13 - Flags are sampled, polled and resolved every machine cycle. The code polls only while seq is FLIP_IDLE, not during a call sequence.
// RULE14 - Call only when no equal or higher level is in service, last cycle.
// RULE15 - No call when the instruction writes enable/priority or is a return.
// RULE16 - Requests are not latched; every polling cycle is judged afresh.
// RULE17 - Call pushes the program counter, not status, then loads the vector.
// RULE18 - Vectoring clears timer0/1 flags, and ext0/1 flags in edge mode.
// RULE19 - Software clears serial, timer2 and watchdog flags itself.
// RULE20 - Shared-vector sources request on the OR of their flags.
// RULE21 - Global enable bit cleared blocks every request.
// RULE22 - The call takes four machine cycles after the polling cycle.
// RULE23 - A source joins only with flag, own enable and global enable set.
// RULE24 - In-service level tracked per level; return releases the highest.
`timescale 1ns/10ps
`include "flip_map.svh"
module flip_core
  import flip_pkg::*;
(
  // Clock and reset.
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  // Peripheral flags.
  input  wire logic        ext0_flag_i,
  input  wire logic        timer0_ovf_flag_i,
  input  wire logic        ext1_flag_i,
  input  wire logic        timer1_ovf_flag_i,
  input  wire logic        rx_done_flag_i,
  input  wire logic        tx_done_flag_i,
  input  wire logic        timer2_ovf_flag_i,
  input  wire logic        timer2_ext_flag_i,
  input  wire logic        adc_done_flag_i,
  input  wire logic        twowire_flag_i,
  input  wire logic        rx1_done_flag_i,
  input  wire logic        tx1_done_flag_i,
  input  wire logic        spi_xfer_done_flag_i,
  input  wire logic        spi_mode_fault_flag_i,
  input  wire logic        spi_overrun_flag_i,
  input  wire logic        ext2_flag_i,
  input  wire logic        ext3_flag_i,
  input  wire logic        ext4_flag_i,
  input  wire logic        ext5_flag_i,
  input  wire logic        pwm_period_flag_i,
  input  wire logic        brake_flag_i,
  input  wire logic        timer3_ovf_flag_i,
  input  wire logic        capture0_flag_i,
  input  wire logic        quad_enc_flag_i,
  input  wire logic        capture1_flag_i,
  input  wire logic        direction_change_flag_i,
  input  wire logic        capture2_flag_i,
  input  wire logic        nvm_done_flag_i,
  input  wire logic        wdog_timeout_flag_i,
  // External interrupt trigger modes, high for edge.
  input  wire logic        ext0_edge_mode_i,
  input  wire logic        ext1_edge_mode_i,
  // Enable and priority registers.
  input  wire logic [7:0]  enable_reg_a_i,
  input  wire logic [7:0]  enable_reg_b_i,
  input  wire logic [7:0]  enable_reg_c_i,
  input  wire logic [7:0]  prio_high_bits_a_i,
  input  wire logic [7:0]  prio_low_bits_a_i,
  input  wire logic [7:0]  prio_high_bits_b_i,
  input  wire logic [7:0]  prio_low_bits_b_i,
  input  wire logic [7:0]  prio_high_bits_c_i,
  input  wire logic [7:0]  prio_low_bits_c_i,
  // Instruction sequencer status.
  input  wire logic        last_cycle_i,
  input  wire logic        irq_reg_write_i,
  input  wire logic        reti_i,
  input  wire logic [15:0] pc_i,
  input  wire logic        power_down_i,
  // Machine-cycle strobe.
  output logic             mc_tick_o,
  // Hardware call.
  output logic             call_start_o,
  output logic             call_busy_o,
  output logic             stack_push_o,
  output logic [7:0]       stack_byte_o,
  output logic             pc_load_o,
  output logic [15:0]      pc_load_val_o,
  // Flag clears.
  output logic             clr_timer0_ovf_o,
  output logic             clr_timer1_ovf_o,
  output logic             clr_ext0_o,
  output logic             clr_ext1_o,
  // Status.
  output logic             wakeup_o,
  output logic [3:0]       in_service_o
);
  localparam int NSRC = `FLIP_NUM_SRC;

  // Element 0 is the best rank; the lists are written last element first.
  localparam logic [19:0][4:0] POS = { // RULE5 RULE9 RULE10 RULE11
    `FLIP_POS_WDOG,    `FLIP_POS_NVM,     `FLIP_POS_CAPTURE, `FLIP_POS_TIMER3,
    `FLIP_POS_BRAKE,   `FLIP_POS_PWM,     `FLIP_POS_EXT5,    `FLIP_POS_EXT4,
    `FLIP_POS_EXT3,    `FLIP_POS_EXT2,    `FLIP_POS_SPI,     `FLIP_POS_SERIAL1,
    `FLIP_POS_TWOWIRE, `FLIP_POS_ADC,     `FLIP_POS_TIMER2,  `FLIP_POS_SERIAL0,
    `FLIP_POS_TIMER1,  `FLIP_POS_EXT1,    `FLIP_POS_TIMER0,  `FLIP_POS_EXT0
  };

  localparam logic [19:0][15:0] VEC = { // RULE6 RULE7 RULE8
    `FLIP_VEC_WDOG,    `FLIP_VEC_NVM,     `FLIP_VEC_CAPTURE, `FLIP_VEC_TIMER3,
    `FLIP_VEC_BRAKE,   `FLIP_VEC_PWM,     `FLIP_VEC_EXT5,    `FLIP_VEC_EXT4,
    `FLIP_VEC_EXT3,    `FLIP_VEC_EXT2,    `FLIP_VEC_SPI,     `FLIP_VEC_SERIAL1,
    `FLIP_VEC_TWOWIRE, `FLIP_VEC_ADC,     `FLIP_VEC_TIMER2,  `FLIP_VEC_SERIAL0,
    `FLIP_VEC_TIMER1,  `FLIP_VEC_EXT1,    `FLIP_VEC_TIMER0,  `FLIP_VEC_EXT0
  };

  flip_core_t s_reg;
  flip_core_t s_next;

  logic [NSRC-1:0]      flag;
  logic [NSRC-1:0]      req;
  logic [NSRC-1:0][1:0] lvl;
  logic [23:0]          en_all;
  logic [23:0]          ph_all;
  logic [23:0]          pl_all;
  logic                 win_valid;
  logic [4:0]           win_idx;
  logic [1:0]           win_lvl;
  logic [3:0]           isr_active;
  logic                 isr_top_valid;
  logic [1:0]           isr_top_lvl;
  logic                 accept;
  logic                 release_lvl;

  assign en_all = {enable_reg_c_i, enable_reg_b_i, enable_reg_a_i};
  assign ph_all = {prio_high_bits_c_i, prio_high_bits_b_i, prio_high_bits_a_i};
  assign pl_all = {prio_low_bits_c_i, prio_low_bits_b_i, prio_low_bits_a_i};

  // Flag vector in rank order; shared vectors see the OR of their flags.
  assign flag = { // RULE20
    wdog_timeout_flag_i,
    nvm_done_flag_i,
    capture0_flag_i | quad_enc_flag_i | capture1_flag_i | direction_change_flag_i | capture2_flag_i,
    timer3_ovf_flag_i,
    brake_flag_i,
    pwm_period_flag_i,
    ext5_flag_i,
    ext4_flag_i,
    ext3_flag_i,
    ext2_flag_i,
    spi_xfer_done_flag_i | spi_mode_fault_flag_i | spi_overrun_flag_i,
    rx1_done_flag_i | tx1_done_flag_i,
    twowire_flag_i,
    adc_done_flag_i,
    timer2_ovf_flag_i | timer2_ext_flag_i,
    rx_done_flag_i | tx_done_flag_i,
    timer1_ovf_flag_i,
    ext1_flag_i,
    timer0_ovf_flag_i,
    ext0_flag_i
  };

  // Requests are rebuilt from the live flags each poll and never held here.
  for (genvar g = 0; g < NSRC; g++) begin : g_src
    assign req[g] = flag[g] & en_all[POS[g]] & en_all[`FLIP_GLOBAL_EN_BIT]; // RULE16 RULE21 RULE23
    assign lvl[g] = {ph_all[POS[g]], pl_all[POS[g]]}; // RULE1
  end

  flip_arbiter u_arbiter (
    .req_i       (req),
    .lvl_i       (lvl),
    .win_valid_o (win_valid),
    .win_idx_o   (win_idx),
    .win_lvl_o   (win_lvl)
  );

  flip_inservice u_inservice (
    .ref_clk_i   (ref_clk_i),
    .resetn_i    (resetn_i),
    .set_i       (accept),
    .set_lvl_i   (win_lvl),
    .release_i   (release_lvl),
    .active_o    (isr_active),
    .top_valid_o (isr_top_valid),
    .top_lvl_o   (isr_top_lvl)
  );

  // A call is judged only on the machine-cycle strobe, never mid-sequence.
  always_comb begin
    accept = s_reg.tick && (s_reg.seq == FLIP_IDLE) && win_valid // RULE13
           && (!isr_top_valid || win_lvl > isr_top_lvl) // RULE2 RULE14
           && last_cycle_i // RULE14
           && !irq_reg_write_i && !reti_i; // RULE15
  end

  assign release_lvl = s_reg.tick && reti_i && last_cycle_i; // RULE24

  always_comb begin
    s_next = s_reg;
    s_next.call_start = 1'b0;
    s_next.push       = 1'b0;
    s_next.pc_load    = 1'b0;
    s_next.clr_timer0 = 1'b0;
    s_next.clr_timer1 = 1'b0;
    s_next.clr_ext0   = 1'b0;
    s_next.clr_ext1   = 1'b0;

    // Machine-cycle divider; the strobe is a one-clock pulse.
    s_next.tick = (s_reg.div == `FLIP_DIV_LAST);
    if (s_reg.div == `FLIP_DIV_LAST) begin
      s_next.div = `FLIP_DIV_RST;
    end else begin
      s_next.div = s_reg.div + 2'h1;
    end

    // Only the ext0 and ext1 sources may wake the chip.
    s_next.wake = power_down_i && (req[`FLIP_SRC_EXT0] || req[`FLIP_SRC_EXT1]); // RULE12

    case (s_reg.seq)
      FLIP_IDLE: begin
        if (accept) begin
          s_next.seq        = FLIP_PUSH_LO;
          s_next.busy       = 1'b1;
          s_next.call_start = 1'b1;
          s_next.vector     = VEC[win_idx];
          s_next.ret_pc     = pc_i;
          s_next.clr_timer0 = (win_idx == `FLIP_SRC_TIMER0); // RULE18
          s_next.clr_timer1 = (win_idx == `FLIP_SRC_TIMER1); // RULE18
          s_next.clr_ext0   = (win_idx == `FLIP_SRC_EXT0) && ext0_edge_mode_i; // RULE18
          s_next.clr_ext1   = (win_idx == `FLIP_SRC_EXT1) && ext1_edge_mode_i; // RULE18
        end
      end
      FLIP_PUSH_LO: begin
        // Only the program counter goes on the stack; status stays put.
        if (s_reg.tick) begin
          s_next.seq       = FLIP_PUSH_HI;
          s_next.push      = 1'b1; // RULE17
          s_next.push_byte = s_reg.ret_pc[7:0];
        end
      end
      FLIP_PUSH_HI: begin
        if (s_reg.tick) begin
          s_next.seq       = FLIP_FETCH;
          s_next.push      = 1'b1; // RULE17
          s_next.push_byte = s_reg.ret_pc[15:8];
        end
      end
      FLIP_FETCH: begin
        if (s_reg.tick) begin
          s_next.seq = FLIP_LOAD; // RULE22
        end
      end
      FLIP_LOAD: begin
        if (s_reg.tick) begin
          s_next.seq     = FLIP_IDLE;
          s_next.busy    = 1'b0;
          s_next.pc_load = 1'b1; // RULE17 RULE22
        end
      end
      default: begin
        s_next.seq  = FLIP_IDLE;
        s_next.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_reg.div        <= `FLIP_DIV_RST;
      s_reg.tick       <= 1'b0;
      s_reg.seq        <= FLIP_IDLE;
      s_reg.vector     <= `FLIP_VEC_RST;
      s_reg.ret_pc     <= `FLIP_VEC_RST;
      s_reg.call_start <= 1'b0;
      s_reg.busy       <= 1'b0;
      s_reg.push       <= 1'b0;
      s_reg.push_byte  <= 8'h00;
      s_reg.pc_load    <= 1'b0;
      s_reg.clr_timer0 <= 1'b0;
      s_reg.clr_timer1 <= 1'b0;
      s_reg.clr_ext0   <= 1'b0;
      s_reg.clr_ext1   <= 1'b0;
      s_reg.wake       <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign mc_tick_o        = s_reg.tick;
  assign call_start_o     = s_reg.call_start;
  assign call_busy_o      = s_reg.busy;
  assign stack_push_o     = s_reg.push;
  assign stack_byte_o     = s_reg.push_byte;
  assign pc_load_o        = s_reg.pc_load;
  assign pc_load_val_o    = s_reg.vector;
  assign clr_timer0_ovf_o = s_reg.clr_timer0;
  assign clr_timer1_ovf_o = s_reg.clr_timer1;
  assign clr_ext0_o       = s_reg.clr_ext0;
  assign clr_ext1_o       = s_reg.clr_ext1;
  assign wakeup_o         = s_reg.wake;
  assign in_service_o     = isr_active;
endmodule

/* File: rtl/flip_map.svh */
// Constant map of the four-level interrupt priority block.
`ifndef FLIP_MAP_SVH
`define FLIP_MAP_SVH

// Clock and machine-cycle timing.
`define FLIP_CLK_NS        4
`define FLIP_MC_NS         16
`define FLIP_MC_CLKS       (`FLIP_MC_NS / `FLIP_CLK_NS)
`define FLIP_DIV_LAST      2'(`FLIP_MC_CLKS - 1)
`define FLIP_DIV_RST       2'h0

// Source count and rank indices, best rank first.
`define FLIP_NUM_SRC       20
`define FLIP_SRC_EXT0      5'h00
`define FLIP_SRC_TIMER0    5'h01
`define FLIP_SRC_EXT1      5'h02
`define FLIP_SRC_TIMER1    5'h03

// Bit positions in the 24-bit image {reg_c, reg_b, reg_a}.
`define FLIP_GLOBAL_EN_BIT 5'h07
`define FLIP_POS_EXT0      5'h00
`define FLIP_POS_TIMER0    5'h01
`define FLIP_POS_EXT1      5'h02
`define FLIP_POS_TIMER1    5'h03
`define FLIP_POS_SERIAL0   5'h04
`define FLIP_POS_TIMER2    5'h05
`define FLIP_POS_ADC       5'h06
`define FLIP_POS_TWOWIRE   5'h08
`define FLIP_POS_EXT2      5'h0a
`define FLIP_POS_EXT3      5'h0b
`define FLIP_POS_WDOG      5'h0c
`define FLIP_POS_EXT4      5'h0d
`define FLIP_POS_EXT5      5'h0e
`define FLIP_POS_SERIAL1   5'h0f
`define FLIP_POS_SPI       5'h10
`define FLIP_POS_PWM       5'h11
`define FLIP_POS_BRAKE     5'h12
`define FLIP_POS_TIMER3    5'h13
`define FLIP_POS_CAPTURE   5'h14
`define FLIP_POS_NVM       5'h15

// Vector addresses.
`define FLIP_VEC_EXT0      16'h0003
`define FLIP_VEC_TIMER0    16'h000b
`define FLIP_VEC_EXT1      16'h0013
`define FLIP_VEC_TIMER1    16'h001b
`define FLIP_VEC_SERIAL0   16'h0023
`define FLIP_VEC_TIMER2    16'h002b
`define FLIP_VEC_ADC       16'h0033
`define FLIP_VEC_TWOWIRE   16'h003b
`define FLIP_VEC_SERIAL1   16'h007b
`define FLIP_VEC_SPI       16'h0083
`define FLIP_VEC_EXT2      16'h0043
`define FLIP_VEC_EXT3      16'h004b
`define FLIP_VEC_EXT4      16'h0053
`define FLIP_VEC_EXT5      16'h005b
`define FLIP_VEC_PWM       16'h0073
`define FLIP_VEC_BRAKE     16'h006b
`define FLIP_VEC_TIMER3    16'h008b
`define FLIP_VEC_CAPTURE   16'h0093
`define FLIP_VEC_NVM       16'h009b
`define FLIP_VEC_WDOG      16'h0063

// Reset values.
`define FLIP_VEC_RST       16'h0000
`define FLIP_ACT_RST       4'h0
`define FLIP_LVL_RST       2'h0
`endif

/* File: rtl/flip_pkg.sv */
// Types shared by the interrupt priority block.
package flip_pkg;
  typedef enum logic [4:0] {
    FLIP_IDLE    = 5'h01,
    FLIP_PUSH_LO = 5'h02,
    FLIP_PUSH_HI = 5'h04,
    FLIP_FETCH   = 5'h08,
    FLIP_LOAD    = 5'h10
  } flip_seq_t;

  typedef struct packed {
    logic [1:0]  div;
    logic        tick;
    flip_seq_t   seq;
    logic [15:0] vector;
    logic [15:0] ret_pc;
    logic        call_start;
    logic        busy;
    logic        push;
    logic [7:0]  push_byte;
    logic        pc_load;
    logic        clr_timer0;
    logic        clr_timer1;
    logic        clr_ext0;
    logic        clr_ext1;
    logic        wake;
  } flip_core_t;

  typedef struct packed {
    logic [3:0] active;
  } flip_isr_t;
endpackage

/* File: rtl/flip_arbiter.sv */
// Level-then-rank arbiter over all interrupt requests.
`timescale 1ns/10ps
`include "flip_map.svh"
module flip_arbiter
  import flip_pkg::*;
(
  // Requests and their levels, index 0 is the best rank.
  input  wire logic [19:0]      req_i,
  input  wire logic [19:0][1:0] lvl_i,
  // Winner.
  output logic                  win_valid_o,
  output logic [4:0]            win_idx_o,
  output logic [1:0]            win_lvl_o
);
  // Scanning from the worst rank upward and taking on equal level lets the
  // better rank win a tie while a higher level always wins outright.
  always_comb begin
    win_valid_o = 1'b0;
    win_idx_o   = 5'h00;
    win_lvl_o   = 2'h0;
    for (int i = `FLIP_NUM_SRC - 1; i >= 0; i--) begin
      if (req_i[i] && (!win_valid_o || lvl_i[i] >= win_lvl_o)) begin // RULE3 RULE4
        win_valid_o = 1'b1;
        win_idx_o   = 5'(i);
        win_lvl_o   = lvl_i[i];
      end
    end
  end
endmodule

/* File: rtl/flip_inservice.sv */
// In-service level tracker, one bit per priority level.
`timescale 1ns/10ps
`include "flip_map.svh"
module flip_inservice
  import flip_pkg::*;
(
  // Clock and reset.
  input  wire logic       ref_clk_i,
  input  wire logic       resetn_i,
  // Control.
  input  wire logic       set_i,
  input  wire logic [1:0] set_lvl_i,
  input  wire logic       release_i,
  // State.
  output logic [3:0]      active_o,
  output logic            top_valid_o,
  output logic [1:0]      top_lvl_o
);
  flip_isr_t isr_reg;
  flip_isr_t isr_next;

  assign active_o = isr_reg.active;

  always_comb begin
    top_valid_o = 1'b0;
    top_lvl_o   = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (isr_reg.active[i]) begin
        top_valid_o = 1'b1;
        top_lvl_o   = 2'(i);
      end
    end
  end

  always_comb begin
    isr_next = isr_reg;
    if (release_i && top_valid_o) begin
      isr_next.active[top_lvl_o] = 1'b0; // RULE24
    end
    if (set_i) begin
      isr_next.active[set_lvl_i] = 1'b1; // RULE24
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      isr_reg.active <= `FLIP_ACT_RST;
    end else begin
      isr_reg <= isr_next;
    end
  end
endmodule

/* File: tb/flip_core_assertions.sv */
// Concurrent checks on the ports of the interrupt priority block.
`timescale 1ns/10ps
module flip_core_assertions (
  // Clock and reset.
  input wire logic        ref_clk_i,
  input wire logic        resetn_i,
  // Watched inputs.
  input wire logic        ext0_flag_i,
  input wire logic        ext1_flag_i,
  input wire logic        timer0_ovf_flag_i,
  input wire logic        ext0_edge_mode_i,
  input wire logic [7:0]  enable_reg_a_i,
  input wire logic        last_cycle_i,
  input wire logic        irq_reg_write_i,
  input wire logic        reti_i,
  input wire logic        power_down_i,
  // Watched outputs.
  input wire logic        mc_tick_o,
  input wire logic        call_start_o,
  input wire logic        call_busy_o,
  input wire logic        stack_push_o,
  input wire logic        pc_load_o,
  input wire logic [15:0] pc_load_val_o,
  input wire logic        clr_timer0_ovf_o,
  input wire logic        clr_ext0_o,
  input wire logic        wakeup_o,
  input wire logic [3:0]  in_service_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  tick_spacing_a: assert property (mc_tick_o |=> !mc_tick_o [*3] ##1 mc_tick_o)
    else $error("machine tick spacing wrong");
  call_gating_a: assert property (call_start_o |-> $past(mc_tick_o && last_cycle_i && !irq_reg_write_i
    && !reti_i && enable_reg_a_i[7] && !call_busy_o)) else $error("call without its conditions");
  call_walk_a: assert property (call_start_o |-> ##4 stack_push_o ##4 stack_push_o ##8 (pc_load_o && !call_busy_o))
    else $error("call sequence timing wrong");
  busy_hold_a: assert property (call_start_o |-> call_busy_o [*8])
    else $error("busy dropped early");
  busy_end_a: assert property ($fell(call_busy_o) |-> pc_load_o)
    else $error("busy fell without vector load");
  no_overlap_a: assert property (call_busy_o && $past(call_busy_o) |-> !call_start_o)
    else $error("call started during call");
  vector_hold_a: assert property (!call_start_o |-> $stable(pc_load_val_o))
    else $error("vector changed without call");
  timer_clear_a: assert property (clr_timer0_ovf_o |-> call_start_o && $past(timer0_ovf_flag_i))
    else $error("stray timer clear");
  ext_clear_a: assert property (clr_ext0_o |-> call_start_o && $past(ext0_flag_i && ext0_edge_mode_i))
    else $error("stray external clear");
  wake_follow_a: assert property ($past(resetn_i) |-> wakeup_o == $past(power_down_i && enable_reg_a_i[7]
    && (ext0_flag_i && enable_reg_a_i[0] || ext1_flag_i && enable_reg_a_i[2]))) else $error("wakeup wrong");
  nest_up_a: assert property (call_start_o |-> in_service_o > $past(in_service_o))
    else $error("call without higher level");
  ret_release_a: assert property ($past(mc_tick_o && reti_i && last_cycle_i && in_service_o != 4'h0)
    |-> in_service_o < $past(in_service_o)) else $error("return did not release");

  cover property (call_start_o && in_service_o[3] && in_service_o[0]);
  cover property (wakeup_o);
  cover property (clr_ext0_o);
endmodule

bind flip_core flip_core_assertions u_chk (
  .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .ext0_flag_i(ext0_flag_i), .ext1_flag_i(ext1_flag_i),
  .timer0_ovf_flag_i(timer0_ovf_flag_i), .ext0_edge_mode_i(ext0_edge_mode_i), .enable_reg_a_i(enable_reg_a_i),
  .last_cycle_i(last_cycle_i), .irq_reg_write_i(irq_reg_write_i), .reti_i(reti_i), .power_down_i(power_down_i),
  .mc_tick_o(mc_tick_o), .call_start_o(call_start_o), .call_busy_o(call_busy_o), .stack_push_o(stack_push_o),
  .pc_load_o(pc_load_o), .pc_load_val_o(pc_load_val_o), .clr_timer0_ovf_o(clr_timer0_ovf_o),
  .clr_ext0_o(clr_ext0_o), .wakeup_o(wakeup_o), .in_service_o(in_service_o));

/* File: tb/flip_seq_model.sv */
// Sequencer model that collects the pushed return address and the loaded vector.
`timescale 1ns/10ps
module flip_seq_model (
  // Clock and reset.
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  // Call traffic from the block.
  input  wire logic        stack_push_i,
  input  wire logic [7:0]  stack_byte_i,
  input  wire logic        pc_load_i,
  input  wire logic [15:0] pc_load_val_i,
  // Collected values.
  output logic [15:0]      saved_o,
  output logic [15:0]      loaded_o
);
  logic hi_reg;

  // Pushes arrive in pairs, so a toggle tells low from high.
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hi_reg   <= 1'b0;
      saved_o  <= 16'h0;
      loaded_o <= 16'h0;
    end else begin
      if (stack_push_i) begin
        hi_reg <= !hi_reg;
        if (hi_reg) saved_o[15:8] <= stack_byte_i;
        else saved_o[7:0] <= stack_byte_i;
      end
      if (pc_load_i) loaded_o <= pc_load_val_i;
    end
  end
endmodule

/* File: tb/flip_core_tb.sv */
// Self-checking bench for the interrupt priority block.
`timescale 1ns/10ps
module flip_core_tb;
  logic ref_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [28:0] fl = 29'h0;
  logic [23:0] en = 24'h0, ph = 24'h0, pl = 24'h0;
  logic last = 1'b0, wr = 1'b0, reti = 1'b0, pd = 1'b0;
  logic [1:0] em = 2'h0;
  logic [15:0] pc = 16'h0;
  logic [28:0] nf;
  logic [23:0] nen, nph, npl;
  logic nlast, nwr, nreti, npd;
  logic [1:0] nem;
  logic [15:0] npc, saved, loaded, pc_load_val_o;
  logic [31:0] s = 32'hf6c94d82, r;
  logic mc_tick_o, call_start_o, call_busy_o, stack_push_o, pc_load_o, wakeup_o;
  logic [7:0] stack_byte_o;
  logic [3:0] clr, in_service_o, isv = 4'h0;
  int miscompares = 0, n_tests = 0, cyc = 0;
  int pos[20] = '{0, 1, 2, 3, 4, 5, 6, 8, 15, 16, 10, 11, 13, 14, 17, 18, 19, 20, 21, 12};
  int fb[20] = '{0, 1, 2, 3, 5, 7, 8, 9, 10, 14, 15, 16, 17, 18, 19, 20, 21, 26, 27, 28};
  logic [15:0] vec[20] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023, 16'h002b, 16'h0033, 16'h003b,
    16'h007b, 16'h0083, 16'h0043, 16'h004b, 16'h0053, 16'h005b, 16'h0073, 16'h006b, 16'h008b, 16'h0093,
    16'h009b, 16'h0063};

  always #2 ref_clk_i = !ref_clk_i;

  flip_core DUT (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .ext0_flag_i(fl[0]), .timer0_ovf_flag_i(fl[1]), .ext1_flag_i(fl[2]), .timer1_ovf_flag_i(fl[3]),
    .rx_done_flag_i(fl[4]), .tx_done_flag_i(fl[5]), .timer2_ovf_flag_i(fl[6]), .timer2_ext_flag_i(fl[7]),
    .adc_done_flag_i(fl[8]), .twowire_flag_i(fl[9]), .rx1_done_flag_i(fl[10]), .tx1_done_flag_i(fl[11]),
    .spi_xfer_done_flag_i(fl[12]), .spi_mode_fault_flag_i(fl[13]), .spi_overrun_flag_i(fl[14]),
    .ext2_flag_i(fl[15]), .ext3_flag_i(fl[16]), .ext4_flag_i(fl[17]), .ext5_flag_i(fl[18]),
    .pwm_period_flag_i(fl[19]), .brake_flag_i(fl[20]), .timer3_ovf_flag_i(fl[21]), .capture0_flag_i(fl[22]),
    .quad_enc_flag_i(fl[23]), .capture1_flag_i(fl[24]), .direction_change_flag_i(fl[25]),
    .capture2_flag_i(fl[26]), .nvm_done_flag_i(fl[27]), .wdog_timeout_flag_i(fl[28]),
    .ext0_edge_mode_i(em[0]), .ext1_edge_mode_i(em[1]),
    .enable_reg_a_i(en[7:0]), .enable_reg_b_i(en[15:8]), .enable_reg_c_i(en[23:16]),
    .prio_high_bits_a_i(ph[7:0]), .prio_low_bits_a_i(pl[7:0]), .prio_high_bits_b_i(ph[15:8]),
    .prio_low_bits_b_i(pl[15:8]), .prio_high_bits_c_i(ph[23:16]), .prio_low_bits_c_i(pl[23:16]),
    .last_cycle_i(last), .irq_reg_write_i(wr), .reti_i(reti), .pc_i(pc), .power_down_i(pd),
    .mc_tick_o(mc_tick_o), .call_start_o(call_start_o), .call_busy_o(call_busy_o),
    .stack_push_o(stack_push_o), .stack_byte_o(stack_byte_o), .pc_load_o(pc_load_o),
    .pc_load_val_o(pc_load_val_o), .clr_timer0_ovf_o(clr[0]), .clr_timer1_ovf_o(clr[1]),
    .clr_ext0_o(clr[2]), .clr_ext1_o(clr[3]), .wakeup_o(wakeup_o), .in_service_o(in_service_o));

  flip_seq_model u_seq (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .stack_push_i(stack_push_o),
    .stack_byte_i(stack_byte_o), .pc_load_i(pc_load_o), .pc_load_val_i(pc_load_val_o),
    .saved_o(saved), .loaded_o(loaded));

  function automatic logic [31:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // Winner as {valid, level, rank}; walking from worst rank up lets the better rank win a level tie.
  function automatic logic [7:0] win(input logic [28:0] f, input logic [23:0] e, h, l);
    logic [19:0] q;
    logic [7:0] b;
    q = {f[28], f[27], |f[26:22], f[21], f[20], f[19], f[18:15], |f[14:12], f[11] | f[10], f[9], f[8],
      f[7] | f[6], f[5] | f[4], f[3:0]};
    b = 8'h0;
    for (int k = 19; k >= 0; k--) begin
      if (q[k] && e[pos[k]] && e[7] && (!b[7] || {h[pos[k]], l[pos[k]]} >= b[6:5])) begin
        b = {1'b1, h[pos[k]], l[pos[k]], 5'(k)};
      end
    end
    return b;
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // One polling cycle with the prepared inputs; the outcome is judged against the bench model.
  task automatic step();
    logic [7:0] w;
    logic acc;
    int k;
    @(posedge ref_clk_i);
    fl <= nf;
    en <= nen;
    ph <= nph;
    pl <= npl;
    last <= nlast;
    wr <= nwr;
    reti <= nreti;
    pd <= npd;
    em <= nem;
    pc <= npc;
    w = win(nf, nen, nph, npl);
    acc = w[7] && (4'h1 << w[6:5]) > isv && nlast && !nwr && !nreti;
    k = 0;
    do @(negedge ref_clk_i); while (mc_tick_o !== 1'b1 && k++ < 8);
    chk(k > 8, 1'b0);
    @(negedge ref_clk_i);
    chk(call_start_o, acc);
    if (acc) isv[w[6:5]] = 1'b1;
    if (nreti && nlast) begin
      for (int b = 3; b >= 0; b--) begin
        if (isv[b]) begin
          isv[b] = 1'b0;
          break;
        end
      end
    end
    chk(in_service_o, isv);
    chk(wakeup_o, npd && nen[7] && (nf[0] && nen[0] || nf[2] && nen[2]));
    if (acc) begin
      chk(pc_load_val_o, vec[w[4:0]]);
      chk(clr, {nem[1] && w[4:0] == 5'h02, nem[0] && w[4:0] == 5'h00, w[4:0] == 5'h03, w[4:0] == 5'h01});
      k = 0;
      while (call_busy_o !== 1'b0 && k++ < 40) @(negedge ref_clk_i);
      chk(k > 40, 1'b0);
      // The model takes the vector at the edge after the load pulse rises.
      @(negedge ref_clk_i);
      chk(saved, npc);
      chk(loaded, vec[w[4:0]]);
    end
  endtask

  task automatic set(input logic [28:0] f, input logic [23:0] h, input logic rt);
    nf = f;
    nen = 24'hffffff;
    nph = h;
    npl = h;
    {nlast, nwr, nreti, npd, nem} = {1'b1, 1'b0, rt, 1'b0, 2'h3};
    npc = 16'(rnd());
  endtask

  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      results();
    end
  end

  initial begin
    repeat (3) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    set(29'h1fffffff, 24'h0, 1'b0);
    step();
    set(29'h0, 24'h0, 1'b1);
    step();
    set(29'h1fffffff, 24'h001000, 1'b0);
    step();
    step();
    set(29'h0, 24'h0, 1'b1);
    step();
    for (int k = 0; k < 20; k++) begin
      set(29'h1 << fb[k], 24'h0, 1'b0);
      step();
      set(29'h0, 24'h0, 1'b1);
      step();
    end
    $display("test lone sources done");
    // Flags stay as drawn for the whole step; the bench clears no flags, and ignores the clr outputs apart from checking them.
    for (int k = 0; k < 500; k++) begin
      nf = 29'(rnd() & rnd() & rnd());
      nen = 24'(rnd());
      nph = 24'(rnd());
      npl = 24'(rnd());
      r = rnd();
      nen[7] = r[0] | r[1];
      {nlast, nwr, nreti, npd, nem, npc} = {r[2] | r[3], r[4] & r[5] & r[6], r[7] & r[8], r[9], r[11:10], r[31:16]};
      step();
    end
    $display("test random done");
    results();
  end
endmodule
